//--- hw/sar_adc_consts.svh
// Overview of operation
// - Power-on bit starts converting the selected channel back to back automatically.
// - Each conversion is a sample phase then an 8-step hold phase.
// - Conversions repeat continuously while powered on.
// - Completion sets the complete flag; no interrupt exists.
// - Result register keeps the last value until the next conversion ends.
// - Complete flag, bit 7, clears on result read or status write.
// - Status write with power on aborts, clears the flag and restarts sampling.
// - Inputs above or below the references saturate to ff or 00.
// - Channel field bits 2:0 select inputs zero to four.
// - Power-on bit 5 switches converter and amplifier together.
// - Converter clock is CPU/2, CPU, or CPU/4 from slow and fast bits.
// - Gain select bit 2 routes the input through a gain of eight.
// - Selecting the gain stage adds no startup delay.
// - Amplifier register bits 7:4 and 1:0 always read zero.
// - Converter runs in wait mode and is disabled in halt mode.
// - Result register is read-only, eight bits, reset to zero.
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH
`define ADC_CSR_OFFSET 8'h34
`define ADC_RESULT_OFFSET 8'h35
`define ADC_AMP_OFFSET 8'h36
`define CSR_DONE_BIT 7
`define CSR_FAST_BIT 6
`define CSR_PWR_BIT 5
`define AMP_SLOW_BIT 3
`define AMP_GAIN_BIT 2
`define CSR_WMASK 8'h67
`define AMP_WMASK 8'h0c
`define SAMPLE_CYCLES 4
`define SAR_STEPS 8
`endif

//--- hw/sar_adc_pkg.sv
package sar_adc_pkg;
    typedef enum logic [1:0] {ST_OFF, ST_SAMPLE, ST_HOLD} phase_t;
    typedef struct packed {
        logic [2:0] channel;
        logic sample;
        logic gain;
        logic powered;
        logic [7:0] trial;
    } analog_ctrl_t;
    typedef struct packed {
        phase_t phase;
        logic [7:0] control_status_register;
        logic [7:0] amp;
        logic [7:0] result;
        logic [7:0] sar;
        logic [7:0] bitmask;
        logic [3:0] count;
        logic [1:0] div;
        logic [31:0] rdata;
        logic ack;
        logic cmp_q1;
        logic cmp_q2;
        logic halt_q1;
        logic halt_q2;
        analog_ctrl_t actrl;
    } state_t;
endpackage : sar_adc_pkg

//--- hw/sar_adc_sequencer.sv
// The Wishbone register port was chosen for this implementation.
`include "sar_adc_consts.svh"
module sar_adc_sequencer
    import sar_adc_pkg::*;
#(
    parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Analog front end
    input wire logic comparator_i,
    input wire logic halt_mode_i,
    output analog_ctrl_t analog_o
);
    initial begin
        if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 15) begin
            $error("SAMPLE_CYCLES must be 1 to 15");
        end
    end

    localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_CYCLES - 1);

    state_t s_reg;
    state_t s_next;

    logic req;
    logic wr_csr;
    logic rd_res;
    logic wr_amp;
    logic tick;
    logic powered;

    always_comb begin
        s_next = s_reg;
        req = wb_cyc_i && wb_stb_i && !s_reg.ack;
        wr_csr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == `ADC_CSR_OFFSET;
        wr_amp = req && wb_we_i && wb_sel_i[0] && wb_adr_i == `ADC_AMP_OFFSET;
        rd_res = req && !wb_we_i && wb_adr_i == `ADC_RESULT_OFFSET;
        s_next.cmp_q1 = comparator_i;
        s_next.cmp_q2 = s_reg.cmp_q1;
        s_next.halt_q1 = halt_mode_i;
        s_next.halt_q2 = s_reg.halt_q1;
        powered = s_reg.control_status_register[`CSR_PWR_BIT] && !s_reg.halt_q2;
        s_next.div = s_reg.div + 2'd1;
        if (s_reg.amp[`AMP_SLOW_BIT]) begin
            tick = s_reg.div == 2'd3;
        end else if (s_reg.control_status_register[`CSR_FAST_BIT]) begin
            tick = 1'b1;
        end else begin
            tick = s_reg.div[0];
        end
        s_next.ack = req;
        s_next.rdata = 32'h0;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                `ADC_CSR_OFFSET: s_next.rdata = {24'h0, s_reg.control_status_register};
                `ADC_RESULT_OFFSET: s_next.rdata = {24'h0, s_reg.result};
                `ADC_AMP_OFFSET: s_next.rdata = {24'h0, s_reg.amp & `AMP_WMASK};
                default: s_next.rdata = 32'h0;
            endcase
        end
        if (wr_amp) begin
            s_next.amp = wb_dat_i[7:0] & `AMP_WMASK;
        end
        unique case (s_reg.phase)
            ST_OFF: begin
                if (powered) begin
                    s_next.phase = ST_SAMPLE;
                    s_next.count = 4'd0;
                end
            end
            ST_SAMPLE: begin
                if (tick) begin
                    if (s_reg.count == SAMPLE_LAST) begin
                        s_next.phase = ST_HOLD;
                        s_next.sar = 8'h80;
                        s_next.bitmask = 8'h80;
                    end else begin
                        s_next.count = s_reg.count + 4'd1;
                    end
                end
            end
            ST_HOLD: begin
                if (tick) begin
                    // saturation is the natural SAR outcome
                    s_next.sar = s_reg.cmp_q2 ? s_reg.sar : s_reg.sar & ~s_reg.bitmask;
                    s_next.bitmask = s_reg.bitmask >> 1;
                    s_next.sar = s_next.sar | (s_reg.bitmask >> 1);
                    if (s_reg.bitmask == 8'h01) begin
                        s_next.result = s_reg.cmp_q2 ? s_reg.sar : s_reg.sar & 8'hfe;
                        s_next.control_status_register[`CSR_DONE_BIT] = 1'b1;
                        s_next.phase = ST_SAMPLE;
                        s_next.count = 4'd0;
                    end
                end
            end
            default: s_next.phase = ST_OFF;
        endcase
        if (rd_res && !(s_next.control_status_register[`CSR_DONE_BIT] && !s_reg.control_status_register[`CSR_DONE_BIT])) begin
            s_next.control_status_register[`CSR_DONE_BIT] = 1'b0;
        end
        if (wr_csr) begin
            s_next.control_status_register = wb_dat_i[7:0] & `CSR_WMASK;
            if (wb_dat_i[`CSR_PWR_BIT]) begin
                s_next.phase = ST_SAMPLE;
                s_next.count = 4'd0;
            end
        end
        if (!powered) begin
            s_next.phase = ST_OFF;
        end
        s_next.actrl.channel = s_next.control_status_register[2:0];
        s_next.actrl.powered = s_next.control_status_register[`CSR_PWR_BIT] && !s_reg.halt_q2;
        s_next.actrl.gain = s_next.amp[`AMP_GAIN_BIT] && s_next.control_status_register[`CSR_PWR_BIT] && !s_reg.halt_q2;
        s_next.actrl.sample = s_next.phase == ST_SAMPLE;
        s_next.actrl.trial = s_next.phase == ST_HOLD ? s_next.sar : 8'h00;
        // auto start held by ST_OFF exit
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.phase <= ST_OFF;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_dat_o = s_reg.rdata;
    assign wb_ack_o = s_reg.ack;
    assign analog_o = s_reg.actrl;
endmodule : sar_adc_sequencer

//--- testbench/sar_adc_asserts.sv
module sar_adc_asserts
    import sar_adc_pkg::*;
(
    input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i, wb_dat_o,
    input wire logic wb_ack_o, comparator_i, halt_mode_i,
    input analog_ctrl_t analog_o
);
    timeunit 1ns / 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack held");
    property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper data set");
    property p_amp; wb_ack_o && !wb_we_i && wb_adr_i == 8'h36 |-> wb_dat_o[7:4] == 4'h0 && wb_dat_o[1:0] == 2'h0; endproperty
    a_amp: assert property (p_amp) else $error("reserved set");
    property p_gain; analog_o.gain |-> analog_o.powered; endproperty
    a_gain: assert property (p_gain) else $error("gain unpowered");
    property p_off; wb_ack_o && wb_we_i && wb_adr_i == 8'h34 && wb_sel_i[0] && !wb_dat_i[5] |-> ##[1:2] !analog_o.powered; endproperty
    a_off: assert property (p_off) else $error("still on");
    property p_halt; halt_mode_i [*5] |-> !analog_o.powered; endproperty
    a_halt: assert property (p_halt) else $error("on in halt");
    property p_hold; $fell(analog_o.sample) && analog_o.powered |=> (!analog_o.sample || wb_we_i) [*7]; endproperty
    a_hold: assert property (p_hold) else $error("hold short");
    c_read: cover property (wb_ack_o && wb_adr_i == 8'h35);
    c_samp: cover property ($rose(analog_o.sample));
    c_gain: cover property (analog_o.gain);
endmodule : sar_adc_asserts
bind sar_adc_sequencer sar_adc_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comparator_i(comparator_i), .halt_mode_i(halt_mode_i),
    .analog_o(analog_o));

//--- testbench/adc_front_model.sv
module adc_front_model
    import sar_adc_pkg::*;
(
    input wire logic clk_i,
    input analog_ctrl_t analog_i,
    input wire logic [4:0][7:0] level_i,
    output logic comparator_o = 1'b0
);
    timeunit 1ns / 1ns;
    logic [7:0] lv;
    logic [7:0] code;
    assign lv = level_i[analog_i.channel];
    assign code = analog_i.gain ? (lv > 8'h1f ? 8'hff : lv << 3) : lv;
    // full scale compare; toggles when off
    always @(posedge clk_i) begin
        comparator_o <= analog_i.powered ? (code >= analog_i.trial) : ~comparator_o;
    end
endmodule : adc_front_model

//--- testbench/sar_adc_sequencer_tb_top.sv
module sar_adc_sequencer_tb_top;
    import sar_adc_pkg::*;
    timeunit 1ns / 1ns;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, halt = 0, cmp, ack;
    logic [7:0] adr = 8'h00, q;
    logic [31:0] dat = 32'h0, dat_o;
    logic [4:0][7:0] lvl = {8'hc3, 8'h7e, 8'hff, 8'h10, 8'h00};
    analog_ctrl_t act;
    int fail_count = 0, tests_run = 0, n;
    sar_adc_sequencer #(.SAMPLE_CYCLES(2)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .comparator_i(cmp), .halt_mode_i(halt), .analog_o(act));
    adc_front_model i_afe (.clk_i(clk_i), .analog_i(act), .level_i(lvl), .comparator_o(cmp));
    initial forever #50 clk_i = ~clk_i;
    task automatic test_done;
        if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk_i);
        {cyc, stb, we} <= {2'b11, w};
        adr <= a;
        dat <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = dat_o[7:0];
        {cyc, stb} <= 2'b00;
        if (k >= 20) begin
            fail_count++;
            test_done();
        end
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(q, e);
    endtask : rd
    task automatic wait_done;
        for (n = 0; n < 100; n++) begin
            wb(1'b0, 8'h34, 8'h00);
            if (q[7]) break;
        end
        if (n >= 100) begin
            fail_count++;
            test_done();
        end
    endtask : wait_done
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        rd(8'h34, 8'h00);
        rd(8'h35, 8'h00);
        rd(8'h40, 8'h00);
        wb(1'b1, 8'h36, 8'hff);
        rd(8'h36, 8'h0c);
        wb(1'b1, 8'h35, 8'h55);
        rd(8'h35, 8'h00);
        wb(1'b1, 8'h36, 8'h08);
        for (int c = 0; c < 5; c++) begin
            wb(1'b1, 8'h34, 8'h20 | c[7:0]);
            wait_done();
            rd(8'h35, lvl[c]);
            rd(8'h34, 8'h20 | c[7:0]);
        end
        rd(8'h35, 8'hc3);
        wb(1'b1, 8'h36, 8'h0c);
        wb(1'b1, 8'h34, 8'h21);
        wait_done();
        wb(1'b0, 8'h35, 8'h00);
        wait_done();
        rd(8'h35, 8'h80);
        wait_done();
        wb(1'b1, 8'h34, 8'h21);
        rd(8'h34, 8'h21);
        halt <= 1;
        repeat (8) @(posedge clk_i);
        chk({7'h0, act.powered}, 8'h00);
        halt <= 0;
        wb(1'b1, 8'h34, 8'h40);
        rd(8'h34, 8'h40);
        test_done();
    end
endmodule : sar_adc_sequencer_tb_top
